// ===== core/svd_ctrl.sv
// Purpose : Control wrapper for the supply high/low voltage event detector
// Assumes : Comparator output is high while supply is at or above the trip point
// Notes   : Register reads return data in the cycle after the read strobe
module svd_ctrl (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       supply_above_i,
    input  wire logic       ref_stable_i,
    input  wire logic       sleep_i,
    output logic            detector_enable_o,
    output logic [3:0]      trip_level_select_o,
    output logic            external_detect_input_o,
    output logic            wake_o,
    output logic            irq_high_o,
    output logic            irq_low_o,
    output logic            vector_o,
    output logic            irq_o
);

    svd_pkg::svd_bus_req_t req;
    svd_pkg::svd_control_t control_reg;
    svd_pkg::svd_control_t control_next;
    logic                  gie_reg;
    logic                  gie_next;
    logic                  peie_reg;
    logic                  peie_next;
    logic                  flag_reg;
    logic                  flag_next;
    logic                  ie_reg;
    logic                  ie_next;
    logic                  ip_reg;
    logic                  ip_next;
    logic [svd_pkg::SVD_ST_W-1:0] evstat_reg;
    logic [svd_pkg::SVD_ST_W-1:0] evstat_next;
    logic [svd_pkg::SVD_ST_W-1:0] evmask_reg;
    logic [svd_pkg::SVD_ST_W-1:0] evmask_next;
    logic [7:0]            rdata_reg;
    logic [7:0]            rdata_next;
    logic                  stable_d_reg;
    logic [svd_pkg::SVD_SYNC_W-1:0] sync_out;
    logic                  above_s;
    logic                  stable_s;
    logic                  trip_cond;
    logic                  trip_set;
    logic                  stable_rise;
    logic [svd_pkg::SVD_ST_W-1:0] ev_set;
    svd_pkg::svd_irq_state_t irq_st;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic wr_hit(input svd_pkg::svd_bus_req_t r, input logic [2:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    // comparator synchroniser
    svd_sync u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i ({ref_stable_i, supply_above_i}),
        .sync_o  (sync_out)
    );

    assign above_s  = sync_out[0];
    assign stable_s = sync_out[1];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    always_comb begin
        trip_cond = control_reg.direction_select ? above_s : ~above_s;
        trip_set    = control_reg.detector_enable && stable_s && trip_cond;
        stable_rise = control_reg.detector_enable && stable_s && !stable_d_reg;
        ev_set      = '0;
        ev_set[svd_pkg::SVD_BIT_ST_TRIP]   = trip_set;
        ev_set[svd_pkg::SVD_BIT_ST_STABLE] = stable_rise;
    end

    // ------------------------------------------------------------
    // Register next state
    // ------------------------------------------------------------
    always_comb begin
        control_next = control_reg;
        gie_next     = gie_reg;
        peie_next    = peie_reg;
        ie_next      = ie_reg;
        ip_next      = ip_reg;
        evmask_next  = evmask_reg;
        flag_next    = flag_reg;
        if (wr_hit(req, svd_pkg::SVD_ADDR_CONTROL)) begin
            control_next = svd_pkg::svd_control_t'(req.wdata & svd_pkg::SVD_CONTROL_WMSK);
        end
        control_next.reference_stable_flag = control_reg.detector_enable && stable_s;
        control_next.unused6 = 1'b0;
        if (wr_hit(req, svd_pkg::SVD_ADDR_INTCTL)) begin
            gie_next  = req.wdata[svd_pkg::SVD_BIT_GLOBAL_EN];
            peie_next = req.wdata[svd_pkg::SVD_BIT_PERIPH_EN];
        end
        if (wr_hit(req, svd_pkg::SVD_ADDR_ENABLES2)) begin
            ie_next = req.wdata[svd_pkg::SVD_BIT_EVENT];
        end
        if (wr_hit(req, svd_pkg::SVD_ADDR_PRIO2)) begin
            ip_next = req.wdata[svd_pkg::SVD_BIT_EVENT];
        end
        if (wr_hit(req, svd_pkg::SVD_ADDR_EVMASK)) begin
            evmask_next = req.wdata[svd_pkg::SVD_ST_W-1:0];
        end
        if (wr_hit(req, svd_pkg::SVD_ADDR_FLAGS2)) begin
            flag_next = req.wdata[svd_pkg::SVD_BIT_EVENT];
        end
        if (trip_set) begin
            flag_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sticky event status, write one to clear
    // ------------------------------------------------------------
    always_comb begin
        evstat_next = evstat_reg;
        if (wr_hit(req, svd_pkg::SVD_ADDR_EVSTAT)) begin
            evstat_next = evstat_reg & ~req.wdata[svd_pkg::SVD_ST_W-1:0];
        end
        evstat_next = evstat_next | ev_set;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = svd_pkg::SVD_BYTE_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                svd_pkg::SVD_ADDR_CONTROL:  rdata_next = control_reg;
                svd_pkg::SVD_ADDR_INTCTL: begin
                    rdata_next[svd_pkg::SVD_BIT_GLOBAL_EN] = gie_reg;
                    rdata_next[svd_pkg::SVD_BIT_PERIPH_EN] = peie_reg;
                end
                svd_pkg::SVD_ADDR_FLAGS2:   rdata_next[svd_pkg::SVD_BIT_EVENT] = flag_reg;
                svd_pkg::SVD_ADDR_ENABLES2: rdata_next[svd_pkg::SVD_BIT_EVENT] = ie_reg;
                svd_pkg::SVD_ADDR_PRIO2:    rdata_next[svd_pkg::SVD_BIT_EVENT] = ip_reg;
                svd_pkg::SVD_ADDR_EVSTAT:   rdata_next[svd_pkg::SVD_ST_W-1:0] = evstat_reg;
                svd_pkg::SVD_ADDR_EVMASK:   rdata_next[svd_pkg::SVD_ST_W-1:0] = evmask_reg;
                default:                    rdata_next = svd_pkg::SVD_BYTE_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // reset restores all registers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            control_reg  <= svd_pkg::svd_control_t'(svd_pkg::SVD_CONTROL_RST);
            gie_reg      <= 1'b0;
            peie_reg     <= 1'b0;
            flag_reg     <= 1'b0;
            ie_reg       <= 1'b0;
            ip_reg       <= 1'b0;
            evstat_reg   <= '0;
            evmask_reg   <= '0;
            rdata_reg    <= svd_pkg::SVD_BYTE_ZERO;
            stable_d_reg <= 1'b0;
        end else begin
            control_reg  <= control_next;
            gie_reg      <= gie_next;
            peie_reg     <= peie_next;
            flag_reg     <= flag_next;
            ie_reg       <= ie_next;
            ip_reg       <= ip_next;
            evstat_reg   <= evstat_next;
            evmask_reg   <= evmask_next;
            rdata_reg    <= rdata_next;
            stable_d_reg <= control_reg.detector_enable && stable_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign irq_st = '{global_irq_enable: gie_reg, peripheral_irq_enable: peie_reg,
                      voltage_event_flag: flag_reg, voltage_event_irq_enable: ie_reg,
                      voltage_event_priority: ip_reg};

    assign rdata_o             = rdata_reg;
    assign detector_enable_o   = control_reg.detector_enable;
    assign trip_level_select_o = control_reg.trip_level_select;
    assign external_detect_input_o = control_reg.trip_level_select == svd_pkg::SVD_LEVEL_EXT;
    // wake path needs no clock gating
    assign wake_o = sleep_i && irq_st.voltage_event_flag;
    // enable gates request, priority routing, global gates
    assign irq_high_o = irq_st.voltage_event_flag && irq_st.voltage_event_irq_enable
                        && irq_st.voltage_event_priority && irq_st.global_irq_enable;
    assign irq_low_o  = irq_st.voltage_event_flag && irq_st.voltage_event_irq_enable
                        && !irq_st.voltage_event_priority && irq_st.global_irq_enable
                        && irq_st.peripheral_irq_enable;
    assign vector_o = irq_high_o || irq_low_o;
    assign irq_o    = |(evstat_reg & evmask_reg);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_flag_on_trip: assert property (@(posedge mclk_i) disable iff (reset_i)
        trip_set |=> flag_reg)
        else $error("event flag not set after trip");

    a_flag_sticky: assert property (@(posedge mclk_i) disable iff (reset_i)
        flag_reg && !wr_hit(req, svd_pkg::SVD_ADDR_FLAGS2) |=> flag_reg)
        else $error("event flag dropped without write");

    a_no_unstable_set: assert property (@(posedge mclk_i) disable iff (reset_i)
        !flag_reg && !stable_s && !wr_hit(req, svd_pkg::SVD_ADDR_FLAGS2) |=> !flag_reg)
        else $error("flag set before reference stable");

    a_wake_request: assert property (@(posedge mclk_i) disable iff (reset_i)
        sleep_i && flag_reg |-> wake_o)
        else $error("no wake request while sleeping with flag");

    a_vector_global: assert property (@(posedge mclk_i) disable iff (reset_i)
        !gie_reg |-> !vector_o)
        else $error("vector without global enable");

    a_enable_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
        !ie_reg |-> !irq_high_o && !irq_low_o)
        else $error("request without event enable");

    a_prio_route: assert property (@(posedge mclk_i) disable iff (reset_i)
        irq_high_o |-> ip_reg && !irq_low_o)
        else $error("priority routing wrong");

    a_unused_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
        $past(rd_i) |-> !rdata_o[6] || ($past(addr_i) == svd_pkg::SVD_ADDR_INTCTL))
        else $error("unimplemented bit read as one");

    a_ext_select: assert property (@(posedge mclk_i) disable iff (reset_i)
        external_detect_input_o == (&trip_level_select_o))
        else $error("external input select mismatch");

    a_stable_follow: assert property (@(posedge mclk_i) disable iff (reset_i)
        !detector_enable_o ##1 !detector_enable_o |-> !control_reg.reference_stable_flag)
        else $error("stable flag set while disabled");

    a_reset_off: assert property (@(posedge mclk_i)
        $fell(reset_i) |-> !detector_enable_o && trip_level_select_o == svd_pkg::SVD_CONTROL_RST[3:0])
        else $error("detector not off after reset");

endmodule

// ===== core/svd_pkg.sv
// Purpose : Constants and types for the supply voltage event controller
// Assumes : Eight-bit registers reached over a plain strobe port
// Notes   : Register indices are byte addresses on the port
//
// Behaviour
// - While enabled, detection keeps working during Sleep without clock suspension.
// - A trip crossing sets the event flag and raises a wake-up request.
// - After wake-up, vector only when the global interrupt enable is set.
// - Any reset returns all registers to reset values, detector disabled.
// - Control: direction bit 7, unused 6, stable 5, enable 4, level 3..0.
// - Unimplemented bits read zero and ignore writes.
// - Event flag sits at bit 2 of the second flag register.
// - Event enable sits at bit 2 of second enable register, gates requests.
// - Priority bit 2 of second priority register selects high or low level.
// - Interrupt control: global enable bit 7 gates both levels, peripheral enable bit 6 gates low level only.
// - Flag sets only once the reference is stable after enabling.
// - Direction clear reports drops to trip, set reports rises to trip.
// - Trip level all ones selects the external detect input.
// - Reference-stable flag is read-only and shows the settled circuit.
package svd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] SVD_ADDR_CONTROL  = 3'h0;
    localparam logic [2:0] SVD_ADDR_INTCTL   = 3'h1;
    localparam logic [2:0] SVD_ADDR_FLAGS2   = 3'h2;
    localparam logic [2:0] SVD_ADDR_ENABLES2 = 3'h3;
    localparam logic [2:0] SVD_ADDR_PRIO2    = 3'h4;
    localparam logic [2:0] SVD_ADDR_EVSTAT   = 3'h5;
    localparam logic [2:0] SVD_ADDR_EVMASK   = 3'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SVD_BIT_EVENT      = 2;
    localparam int SVD_BIT_GLOBAL_EN  = 7;
    localparam int SVD_BIT_PERIPH_EN  = 6;
    localparam int SVD_BIT_ST_TRIP    = 0;
    localparam int SVD_BIT_ST_STABLE  = 1;
    localparam int SVD_ST_W           = 2;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] SVD_CONTROL_RST  = 8'h05;
    localparam logic [7:0] SVD_CONTROL_WMSK = 8'h9F;
    localparam logic [3:0] SVD_LEVEL_EXT    = 4'hF;
    localparam logic [7:0] SVD_BYTE_ZERO    = 8'h00;
    localparam int         SVD_SYNC_W       = 2;

    typedef struct packed {
        logic       direction_select;
        logic       unused6;
        logic       reference_stable_flag;
        logic       detector_enable;
        logic [3:0] trip_level_select;
    } svd_control_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } svd_bus_req_t;

    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic voltage_event_flag;
        logic voltage_event_irq_enable;
        logic voltage_event_priority;
    } svd_irq_state_t;

endpackage

// ===== core/svd_sync.sv
// Purpose : Two-stage synchroniser for the analog level inputs
// Assumes : Inputs come from the comparator and reference, no clock
// Notes   : First stage is read only by the second stage
module svd_sync (
    input  wire logic                        mclk_i,
    input  wire logic                        reset_i,
    input  wire logic [svd_pkg::SVD_SYNC_W-1:0] async_i,
    output logic      [svd_pkg::SVD_SYNC_W-1:0] sync_o
);

    logic [svd_pkg::SVD_SYNC_W-1:0] meta_reg;
    logic [svd_pkg::SVD_SYNC_W-1:0] sync_reg;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

// ===== dv/svd_analog_model.sv
// Purpose : Behavioural comparator and voltage reference beside the controller
// Assumes : Supply is given as a level in trip-step units, external input as an above flag
// Notes   : Comparator output is meaningless while disabled, so it toggles then
module svd_analog_model #(
    parameter int SETTLE = 6
) (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       detector_enable_i,
    input  wire logic [3:0] trip_level_select_i,
    input  wire logic       external_detect_input_i,
    input  wire logic [3:0] supply_lvl_i,
    input  wire logic       ext_above_i,
    output logic            supply_above_o,
    output logic            ref_stable_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] settle_reg;
    logic       toggle_reg;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            settle_reg <= 4'h0;
            toggle_reg <= 1'b0;
        end else begin
            toggle_reg <= ~toggle_reg;
            if (!detector_enable_i) begin
                settle_reg <= 4'h0;
            end else if (settle_reg != 4'(SETTLE)) begin
                settle_reg <= settle_reg + 4'h1;
            end
        end
    end

    assign ref_stable_o = detector_enable_i && (settle_reg == 4'(SETTLE));

    assign supply_above_o = !detector_enable_i ? toggle_reg :
                            external_detect_input_i ? ext_above_i :
                            (supply_lvl_i >= trip_level_select_i);
endmodule

// ===== dv/test_svd_ctrl.sv
// Purpose : Self-checking bench for the supply voltage event controller
// Assumes : Register port with read data one cycle after the strobe
// Notes   : Table rows cover register layout; hand tests cover events
module test_svd_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } svd_row_t;

    logic       mclk_i, reset_i, wr_i, rd_i, sleep_i, ext_above, supply_above, ref_stable;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [3:0] supply_lvl, trip_level_select_o;
    logic       detector_enable_o, external_detect_input_o, wake_o;
    logic       irq_high_o, irq_low_o, vector_o, irq_o;
    int         fail_count, checked;
    svd_row_t   rows [9] = '{
        '{3'h0, 8'h8A, 8'h8A}, '{3'h0, 8'h6F, 8'h0F}, '{3'h1, 8'hFF, 8'hC0},
        '{3'h2, 8'hFF, 8'h04}, '{3'h2, 8'h00, 8'h00}, '{3'h3, 8'hFF, 8'h04},
        '{3'h4, 8'hFF, 8'h04}, '{3'h6, 8'hFF, 8'h03}, '{3'h7, 8'hFF, 8'h00}};

    svd_ctrl u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .supply_above_i(supply_above),
        .ref_stable_i(ref_stable), .sleep_i(sleep_i), .detector_enable_o(detector_enable_o),
        .trip_level_select_o(trip_level_select_o), .external_detect_input_o(external_detect_input_o),
        .wake_o(wake_o), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o), .vector_o(vector_o),
        .irq_o(irq_o));

    svd_analog_model #(.SETTLE(6)) u_analog (.mclk_i(mclk_i), .reset_i(reset_i),
        .detector_enable_i(detector_enable_o), .trip_level_select_i(trip_level_select_o),
        .external_detect_input_i(external_detect_input_o), .supply_lvl_i(supply_lvl),
        .ext_above_i(ext_above), .supply_above_o(supply_above), .ref_stable_o(ref_stable));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    // Event outputs packed as wake, high, low, vector, irq
    task automatic out_chk(input int n, input logic [7:0] exp);
        repeat (n) @(posedge mclk_i);
        #1;
        check({3'h0, wake_o, irq_high_o, irq_low_o, vector_o, irq_o}, exp);
    endtask

    task automatic test_done;
        $display("Checks made %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (5000) @(posedge mclk_i);
        fail_count++;
        test_done;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; sleep_i = 1'b0; addr_i = 3'h0;
        wdata_i = 8'h00; supply_lvl = 4'h8; ext_above = 1'b1;
        fail_count = 0; checked = 0;
        repeat (4) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd_chk(svd_pkg::SVD_ADDR_CONTROL, svd_pkg::SVD_CONTROL_RST);
        for (int a = 1; a < 7; a++) rd_chk(3'(a), 8'h00);
        out_chk(0, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            reg_wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rdata);
        end
        check({7'h0, external_detect_input_o}, 8'h01);
        reg_wr(svd_pkg::SVD_ADDR_INTCTL, 8'h00);
        reg_wr(svd_pkg::SVD_ADDR_ENABLES2, 8'h00);
        reg_wr(svd_pkg::SVD_ADDR_PRIO2, 8'h00);
        reg_wr(svd_pkg::SVD_ADDR_EVMASK, 8'h00);
        $display("table test done");
        // External pin as trip source, low direction
        reg_wr(svd_pkg::SVD_ADDR_CONTROL, 8'h1F);
        out_chk(12, 8'h00);
        rd_chk(svd_pkg::SVD_ADDR_CONTROL, 8'h3F);
        rd_chk(svd_pkg::SVD_ADDR_EVSTAT, 8'h02);
        reg_wr(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        ext_above <= 1'b0;
        rd_chk(svd_pkg::SVD_ADDR_CONTROL, 8'h3F);
        rd_chk(svd_pkg::SVD_ADDR_FLAGS2, 8'h04);
        ext_above <= 1'b1;
        out_chk(4, 8'h00);
        rd_chk(svd_pkg::SVD_ADDR_FLAGS2, 8'h04);
        reg_wr(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        rd_chk(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        reg_wr(svd_pkg::SVD_ADDR_EVSTAT, 8'h03);
        rd_chk(svd_pkg::SVD_ADDR_EVSTAT, 8'h00);
        $display("external input test done");
        // Drop during Sleep wakes and requests
        reg_wr(svd_pkg::SVD_ADDR_CONTROL, 8'h15);
        reg_wr(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        reg_wr(svd_pkg::SVD_ADDR_INTCTL, 8'hC0);
        reg_wr(svd_pkg::SVD_ADDR_ENABLES2, 8'h04);
        reg_wr(svd_pkg::SVD_ADDR_EVMASK, 8'h01);
        sleep_i <= 1'b1;
        out_chk(1, 8'h00);
        supply_lvl <= 4'h4;
        out_chk(2, 8'h00);
        out_chk(1, 8'h17);
        reg_wr(svd_pkg::SVD_ADDR_PRIO2, 8'h04);
        out_chk(0, 8'h1B);
        reg_wr(svd_pkg::SVD_ADDR_INTCTL, 8'h00);
        out_chk(0, 8'h11);
        @(posedge mclk_i);
        sleep_i <= 1'b0;
        out_chk(1, 8'h01);
        supply_lvl <= 4'h8;
        // Let the trip condition drain through the synchroniser before clearing
        out_chk(2, 8'h01);
        reg_wr(svd_pkg::SVD_ADDR_EVSTAT, 8'h01);
        reg_wr(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        out_chk(3, 8'h00);
        $display("sleep event test done");
        // Rise direction, no flag before the reference settles
        reg_wr(svd_pkg::SVD_ADDR_CONTROL, 8'h05);
        reg_wr(svd_pkg::SVD_ADDR_CONTROL, 8'h95);
        out_chk(2, 8'h00);
        rd_chk(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        out_chk(10, 8'h01);
        rd_chk(svd_pkg::SVD_ADDR_FLAGS2, 8'h04);
        $display("rise direction test done");
        @(posedge mclk_i);
        reset_i <= 1'b1;
        out_chk(2, 8'h00);
        @(posedge mclk_i);
        reset_i <= 1'b0;
        rd_chk(svd_pkg::SVD_ADDR_CONTROL, svd_pkg::SVD_CONTROL_RST);
        check({7'h0, detector_enable_o}, 8'h00);
        rd_chk(svd_pkg::SVD_ADDR_FLAGS2, 8'h00);
        $display("mid-run reset test done");
        test_done;
    end
endmodule
